// file: src/dpr_cfg.svh
// Timing counts, widths and register offsets of the dual-port RAM controller
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_ADDR_W 8
`define DPR_DATA_W 16
`define DPR_WORDS 256
`define DPR_CLK_NS 40
// Pin timing in ns, plain defaults
`define DPR_T_AC_NS 80
`define DPR_T_RC_NS 80
`define DPR_T_AS_NS 20
`define DPR_T_WW_NS 60
`define DPR_T_AH_NS 20
`define DPR_T_PW_NS 80
`define DPR_T_PAH_NS 20
// Cycles: least times round up
`define DPR_CYC(ns) (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_AC_CYC `DPR_CYC(`DPR_T_AC_NS)
`define DPR_RC_CYC `DPR_CYC(`DPR_T_RC_NS)
`define DPR_AS_CYC `DPR_CYC(`DPR_T_AS_NS)
`define DPR_WW_CYC `DPR_CYC(`DPR_T_WW_NS)
`define DPR_AH_CYC `DPR_CYC(`DPR_T_AH_NS)
`define DPR_PW_CYC `DPR_CYC(`DPR_T_PW_NS)
`define DPR_PAH_CYC `DPR_CYC(`DPR_T_PAH_NS)
// Register byte offsets
`define DPR_REG_CTRL 4'h0
`define DPR_REG_ADDR 4'h4
`define DPR_REG_WDATA 4'h8
`define DPR_REG_RDATA 4'hc
// Control fields
`define DPR_CTRL_GO 0
`define DPR_CTRL_WR 1
`define DPR_CTRL_SLEEP 2
`define DPR_CTRL_OE 3
// Status fields in control readback
`define DPR_STAT_BUSY 8
`define DPR_STAT_DONE 9
`endif

// file: src/dpr_pkg.sv
// Types of the dual-port RAM controller
package dpr_pkg;
  typedef enum logic [2:0] {
    DprIdle, DprRdSetup, DprRdWait, DprWrSetup, DprWrStrobe, DprWrHold, DprRelease
  } dpr_state_t;
endpackage

// file: src/dpr_pins_if.sv
// Synchronised RAM read-data bundle between the pin syncer and the sequencer
`timescale 1ns/1ps
`include "dpr_cfg.svh"
interface dpr_pins_if;
  logic [`DPR_DATA_W-1:0] data;
  modport src (output data);
  modport dst (input data);
endinterface

// file: src/dpr_sync.sv
// Three-stage synchroniser for the RAM output data bus
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_sync (
  // Clock
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Pins and result
  input wire logic [`DPR_DATA_W-1:0] ramDout,
  dpr_pins_if.src out
);
  logic [`DPR_DATA_W-1:0] s1_q, s2_q, s3_q, held_q;
  // Only the second stage reads the first
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clkEn) begin
      s1_q <= ramDout;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Accept a change once stages two and three agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      held_q <= '0;
    end else if (clkEn && s2_q == s3_q) begin
      held_q <= s3_q;
    end
  end
  assign out.data = held_q;
endmodule

// file: src/dpr_ctrl.sv
// Avalon-MM driven controller that runs read and write cycles on the RAM pins
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_ctrl
  import dpr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // RAM pins
  output logic [`DPR_ADDR_W-1:0] read_addr_bus,
  output logic [`DPR_ADDR_W-1:0] write_addr_bus,
  output logic [`DPR_DATA_W-1:0] ramDin,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic write_strobe_n,
  output logic output_drive_n,
  output logic read_sleep,
  input wire logic [`DPR_DATA_W-1:0] ramDout
);
  dpr_state_t state_q;
  logic [7:0] cnt_q;
  logic [7:0] sleepCnt_q;
  logic [`DPR_ADDR_W-1:0] addr_q;
  logic [`DPR_DATA_W-1:0] wdata_q, rdata_q;
  logic isWr_q, done_q, sleepReq_q, oeReq_q, accept, goPulse, stall, rdAck_q;
  dpr_pins_if pins ();

  // ==========================================
  // Pin data synchroniser
  dpr_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .ramDout(ramDout),
    .out(pins.src)
  );

  function automatic logic [7:0] cyc8(input int n);
    cyc8 = (n < 1) ? 8'h01 : n[7:0];
  endfunction

  // ==========================================
  // Bus slave: reads take one wait state, a start stalls while busy
  // Frozen clock stalls every request, so none is lost while clkEn is low
  assign goPulse = avs_write && avs_address == `DPR_REG_CTRL && avs_writedata[`DPR_CTRL_GO];
  assign stall = !clkEn || (avs_read && !rdAck_q) || (goPulse && state_q != DprIdle);
  assign avs_waitrequest = (avs_read || avs_write) && stall;
  assign accept = avs_write && !avs_waitrequest && clkEn;

  // Read acknowledge: high in the cycle in which registered readdata stands
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdAck_q <= 1'b0;
    end else if (clkEn) begin
      rdAck_q <= avs_read && !rdAck_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (clkEn && avs_read && !rdAck_q) begin
      case (avs_address)
        `DPR_REG_CTRL: begin
          avs_readdata <= 32'h0;
          avs_readdata[`DPR_CTRL_WR] <= isWr_q;
          avs_readdata[`DPR_CTRL_SLEEP] <= sleepReq_q;
          avs_readdata[`DPR_CTRL_OE] <= oeReq_q;
          avs_readdata[`DPR_STAT_BUSY] <= state_q != DprIdle;
          avs_readdata[`DPR_STAT_DONE] <= done_q;
        end
        `DPR_REG_ADDR: avs_readdata <= {{(32-`DPR_ADDR_W){1'b0}}, addr_q};
        `DPR_REG_WDATA: avs_readdata <= {{(32-`DPR_DATA_W){1'b0}}, wdata_q};
        `DPR_REG_RDATA: avs_readdata <= {{(32-`DPR_DATA_W){1'b0}}, rdata_q};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // Software registers, written only at an accepted write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_q <= '0;
      wdata_q <= '0;
      isWr_q <= 1'b0;
      oeReq_q <= 1'b0;
      sleepReq_q <= 1'b0;
    end else if (accept) begin
      case (avs_address)
        `DPR_REG_ADDR: addr_q <= avs_writedata[`DPR_ADDR_W-1:0];
        `DPR_REG_WDATA: wdata_q <= avs_writedata[`DPR_DATA_W-1:0];
        `DPR_REG_CTRL: begin
          isWr_q <= avs_writedata[`DPR_CTRL_WR];
          oeReq_q <= avs_writedata[`DPR_CTRL_OE];
          sleepReq_q <= avs_writedata[`DPR_CTRL_SLEEP];
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Sleep pin: low pulse held at least the minimum width
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      read_sleep <= 1'b1;
      sleepCnt_q <= '0;
    end else if (clkEn) begin
      if (read_sleep && !sleepReq_q && state_q == DprIdle) begin
        read_sleep <= 1'b0;
        sleepCnt_q <= cyc8(`DPR_PW_CYC);
      end else if (!read_sleep && sleepReq_q && sleepCnt_q == 8'h0 && state_q == DprIdle &&
          !(accept && goPulse)) begin
        // A read starting in this cycle must not meet a rising sleep
        read_sleep <= 1'b1;
      end else if (sleepCnt_q != 8'h0) begin
        sleepCnt_q <= sleepCnt_q - 8'h01;
      end
    end
  end

  // ==========================================
  // Cycle sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= DprIdle;
      cnt_q <= '0;
      done_q <= 1'b0;
      rdata_q <= '0;
      read_addr_bus <= '0;
      write_addr_bus <= '0;
      ramDin <= '0;
      read_port_select_n <= 1'b1;
      write_port_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_drive_n <= 1'b1;
    end else if (clkEn) begin
      // Done is cleared by a new write or awake-read start; a finishing cycle sets it again later, an asleep read at once
      output_drive_n <= !oeReq_q;
      if (cnt_q != 8'h0) begin
        cnt_q <= cnt_q - 8'h01;
      end
      case (state_q)
        DprIdle: begin
          if (accept && goPulse) begin
            done_q <= 1'b0;
            if (avs_writedata[`DPR_CTRL_WR]) begin
              write_addr_bus <= addr_q;
              ramDin <= wdata_q;
              write_port_select_n <= 1'b0;
              cnt_q <= cyc8(`DPR_AS_CYC);
              state_q <= DprWrSetup;
            end else if (!read_sleep) begin
              // Address set and select falls at the same edge: access starts on the fall
              read_addr_bus <= addr_q;
              read_port_select_n <= 1'b0;
              cnt_q <= cyc8(`DPR_AC_CYC + 3 > `DPR_RC_CYC ? `DPR_AC_CYC + 3 : `DPR_RC_CYC);
              state_q <= DprRdWait;
            end else begin
              // Asleep reads zeros; no access started
              rdata_q <= '0;
              done_q <= 1'b1;
            end
          end
        end
        DprRdWait: begin
          // Later of access delays plus the three-flop sync
          if (cnt_q == 8'h0) begin
            rdata_q <= pins.data;
            read_port_select_n <= 1'b1;
            cnt_q <= cyc8(`DPR_PAH_CYC);
            state_q <= DprRelease;
          end
        end
        DprWrSetup: begin
          if (cnt_q == 8'h0) begin
            write_strobe_n <= 1'b0;
            cnt_q <= cyc8(`DPR_WW_CYC);
            state_q <= DprWrStrobe;
          end
        end
        DprWrStrobe: begin
          // Address and data frozen while strobe low
          if (cnt_q == 8'h0) begin
            write_strobe_n <= 1'b1;
            cnt_q <= cyc8(`DPR_AH_CYC);
            state_q <= DprWrHold;
          end
        end
        DprWrHold: begin
          if (cnt_q == 8'h0) begin
            write_port_select_n <= 1'b1;
            state_q <= DprRelease;
            cnt_q <= cyc8(`DPR_PAH_CYC);
          end
        end
        DprRelease: begin
          // Read address held after select rises
          if (cnt_q == 8'h0) begin
            done_q <= 1'b1;
            state_q <= DprIdle;
          end
        end
        default: state_q <= DprIdle;
      endcase
    end
  end
endmodule

// file: bench/dpr_ram_model.sv
// Behavioural dual-port RAM with read sleep and output hold
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_ram_model (
  // Read side
  input wire logic [`DPR_ADDR_W-1:0] read_addr_bus,
  input wire logic read_port_select_n,
  input wire logic output_drive_n,
  input wire logic read_sleep,
  // Write side
  input wire logic [`DPR_ADDR_W-1:0] write_addr_bus,
  input wire logic [`DPR_DATA_W-1:0] ramDin,
  input wire logic write_port_select_n,
  input wire logic write_strobe_n,
  // Data out
  output logic [`DPR_DATA_W-1:0] ramDout
);
  logic [`DPR_DATA_W-1:0] mem [`DPR_WORDS];
  logic [`DPR_DATA_W-1:0] held;
  always @(posedge write_strobe_n) begin
    if (!write_port_select_n) begin
      mem[write_addr_bus] <= ramDin;
    end
  end
  // Select rising is not in the list, so it never starts an access
  always @(negedge read_port_select_n or read_addr_bus) begin
    #5;
    if (!read_port_select_n && !read_sleep) begin
      held <= mem[read_addr_bus];
    end
  end
  // Released bus shows the inverse, never a lucky last value
  always_comb begin
    if (read_sleep) ramDout = '0;
    else if (output_drive_n) ramDout = ~held;
    else if (!write_strobe_n && !write_port_select_n && !read_port_select_n) ramDout = ramDin;
    else ramDout = held;
  end
endmodule

// file: bench/dpr_ctrl_asserts.sv
// Checker of the RAM pin sequencing
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_ctrl_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // RAM pins
  input wire logic [`DPR_ADDR_W-1:0] read_addr_bus,
  input wire logic [`DPR_ADDR_W-1:0] write_addr_bus,
  input wire logic [`DPR_DATA_W-1:0] ramDin,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic write_strobe_n,
  input wire logic read_sleep
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ==========
  // Pulse widths
  sequence strobeLow2;
    !write_strobe_n [*2];
  endsequence
  sequence readLow2;
    !read_port_select_n [*2];
  endsequence
  a_strobe_width: assert property ($fell(write_strobe_n) |-> strobeLow2)
    else $error("write strobe pulse too short");
  a_read_access: assert property ($fell(read_port_select_n) |-> readLow2)
    else $error("read select released before access time");
  a_sleep_width: assert property ($fell(read_sleep) |=> !read_sleep)
    else $error("sleep low pulse too short");
  // ==========
  // Address and data stability
  a_strobe_select: assert property (!write_strobe_n |-> !write_port_select_n)
    else $error("strobe low without write select");
  a_waddr_setup: assert property ($fell(write_strobe_n) |-> $stable(write_addr_bus))
    else $error("write address moved at strobe fall");
  a_waddr_hold: assert property (!$past(write_strobe_n) |-> $stable({write_addr_bus, ramDin}))
    else $error("write address or data moved while strobe low");
  a_raddr_stable: assert property (!read_port_select_n && !$past(read_port_select_n) |-> $stable(read_addr_bus))
    else $error("read address moved during a read");
  a_raddr_hold: assert property ($rose(read_port_select_n) || $rose(read_sleep) |-> $stable(read_addr_bus))
    else $error("read address moved at select or sleep rise");
  a_read_awake: assert property (!read_port_select_n |-> !read_sleep)
    else $error("read started while asleep");
endmodule
bind dpr_ctrl dpr_ctrl_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .read_addr_bus(read_addr_bus),
  .write_addr_bus(write_addr_bus), .ramDin(ramDin), .read_port_select_n(read_port_select_n),
  .write_port_select_n(write_port_select_n), .write_strobe_n(write_strobe_n), .read_sleep(read_sleep));

// file: bench/dpr_ctrl_bench.sv
// Self-checking bench of the RAM controller
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_ctrl_bench;
  logic mclk, sys_rst, clkEn, avsRead, avsWrite, waitReq, rSel, wSel, strobe, oeN, sleep;
  logic [3:0] avsAddr;
  logic [31:0] avsWdata, avsRdata, v;
  logic [7:0] rAddr, wAddr, addrs [8];
  logic [15:0] din, dout, expMem [8];
  int fail_count, checks, i;
  dpr_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_readdata(avsRdata),
    .avs_waitrequest(waitReq), .read_addr_bus(rAddr), .write_addr_bus(wAddr), .ramDin(din),
    .read_port_select_n(rSel), .write_port_select_n(wSel), .write_strobe_n(strobe),
    .output_drive_n(oeN), .read_sleep(sleep), .ramDout(dout));
  dpr_ram_model u_ram (.read_addr_bus(rAddr), .read_port_select_n(rSel), .output_drive_n(oeN),
    .read_sleep(sleep), .write_addr_bus(wAddr), .ramDin(din), .write_port_select_n(wSel),
    .write_strobe_n(strobe), .ramDout(dout));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsRead <= rd;
    avsWrite <= !rd;
    avsAddr <= a;
    avsWdata <= d;
    @(posedge mclk);
    while (waitReq !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    v = avsRdata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
    if (n >= 200) begin
      check(32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b1, a, 32'h0);
  endtask
  function automatic logic [31:0] ctrl(input logic go, input logic w, input logic s);
    return {28'h0, 1'b1, s, w, go};
  endfunction
  task automatic op(input logic [7:0] a, input logic [15:0] d, input logic w, input logic s);
    bus(1'b0, 4'h0, ctrl(1'b0, w, s));
    bus(1'b0, 4'h4, {24'h0, a});
    bus(1'b0, 4'h8, {16'h0, d});
    bus(1'b0, 4'h0, ctrl(1'b1, w, s));
    bus(1'b0, 4'h0, ctrl(1'b1, w, s));
    v = 32'h0;
    for (int n = 0; n < 40 && v[9:8] != 2'b10; n++) rd(4'h0);
    check({30'h0, v[9:8]}, 32'h2);
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    {sys_rst, clkEn, avsRead, avsWrite, avsAddr, avsWdata} = {2'b11, 38'h0};
    fail_count = 0;
    checks = 0;
    v = $urandom(32'hbddf7d96);
    repeat (5) @(posedge mclk);
    check({27'h0, sleep, rSel, wSel, strobe, oeN}, 32'h1f);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      addrs[i] = {3'(i), (i == 0) ? 5'h00 : (i == 7) ? 5'h1f : 5'($urandom)};
      expMem[i] = 16'($urandom);
      op(addrs[i], expMem[i], 1'b1, 1'b0);
    end
    for (i = 7; i >= 0; i--) begin
      op(addrs[i], 16'h0, 1'b0, 1'b0);
      rd(4'hc);
      check(v, {16'h0, expMem[i]});
    end
    $display("test write and read back done");
    op(addrs[3], 16'h0, 1'b0, 1'b1);
    rd(4'hc);
    check(v, 32'h0);
    check({31'h0, sleep}, 32'h1);
    op(addrs[2], 16'ha5c3, 1'b1, 1'b1);
    op(addrs[2], 16'h0, 1'b0, 1'b0);
    rd(4'hc);
    check(v, 32'h0000a5c3);
    rd(4'h4);
    check(v, {24'h0, addrs[2]});
    $display("test sleep done");
    bus(1'b0, 4'h0, 32'h0);
    @(posedge mclk);
    check({31'h0, oeN}, 32'h1);
    clkEn <= 1'b0;
    fork
      rd(4'h4);
      begin
        repeat (3) @(posedge mclk);
        check({31'h0, waitReq}, 32'h1);
        repeat (3) @(posedge mclk);
        clkEn <= 1'b1;
      end
    join
    check(v, {24'h0, addrs[2]});
    $display("test output enable and clock enable done");
    finish_test();
  end
endmodule
